// >>> logic/charger_host_defs.vh
`ifndef CHARGER_HOST_DEFS_VH
`define CHARGER_HOST_DEFS_VH
// -----------------------------------------------------------------------
// slave address and register map
// -----------------------------------------------------------------------
`define SLAVE_ADDR      7'h6B
`define REG_COUNT       8'h07
`define REG_STATUS      8'h00
`define UNMAPPED_DATA   8'hFF
`define FAULT_FLD_MSB   2
// -----------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------
`define SYS_CLK_MHZ     100
`define PULSE_US        128
`define PULSE_CYCLES    (`PULSE_US * `SYS_CLK_MHZ)
`define PULSE_CNT_W     14
`endif

// >>> logic/charger_host_interface.v
`timescale 1ns/1ps
`include "charger_host_defs.vh"
// Functional notes
// RL1 - status low while charging, if enabled
// RL2 - otherwise status output left released
// RL3 - faults give one 128 us low pulse
// RL4 - listed events each trigger a pulse
// RL5 - pulses ignore the indicate enable bit
// RL6 - interrupt output mirrors status output exactly
// RL7 - slave only, 100k and 400k alike
// RL8 - 7-bit address 1101011 only
// RL9 - start detected at any time
// RL10 - data changes only while clock low
// RL11 - ack address match on ninth clock
// RL12 - bytes of eight plus acknowledge
// RL13 - direction one writes, zero reads
// RL14 - stop releases link, await start
// RL15 - master stops aborted transfers
// RL16 - unmapped register reads return all ones
// RL17 - fault code keeps first, read clears
// RL18 - counter times pulse, restarts on event
// RL19 - first write byte selects register
module charger_host_interface
(
  input  wire       sys_clk,      // 100 MHz system clock
  input  wire       rstn,         // async reset, active low
  input  wire       sclIn,        // bus clock pin level
  input  wire       sdaIn,        // bus data pin level
  output reg        sdaOut,       // data drive value, always 0
  output reg        sdaOe,        // data pull low when high
  input  wire       charging,     // charge in progress
  input  wire       statEnable,   // status-indicate enable bit
  input  wire [7:0] eventIn,      // one bit per interrupt event
  input  wire [2:0] faultCode,    // live fault code, 0 = none
  input  wire [7:0] statusIn,     // live status bits [7:3]
  input  wire [55:0] regRdData,   // read values of regs 1..6 (8b each)
  output reg        statOut,      // status pin drive value
  output reg        statOe,       // status pin drive low enable
  output reg        intOut,       // interrupt pin drive value
  output reg        intOe,        // interrupt pin drive enable
  output reg        wrStrobe,     // one-cycle register write
  output reg  [7:0] wrAddr,       // register written
  output reg  [7:0] wrData,       // data written
  output reg        faultRead     // one-cycle: fault field read
);
  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  reg [1:0] sclSync;
  reg [1:0] sdaSync;
  reg       sclD;
  reg       sdaD;
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      sclD    <= 1'b1;
      sdaD    <= 1'b1;
    end
    else
    begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      sclD    <= sclSync[1];
      sdaD    <= sdaSync[1];
    end
  end
  wire scl = sclSync[1];
  wire sda = sdaSync[1];
  wire sclRise = scl & ~sclD;
  wire sclFall = ~scl & sclD;
  // start/stop: data edge while clock high; data is legal only to change
  // with clock low, so any such edge is a bus condition
  wire startCond = sclD & scl & sdaD & ~sda;     // [RL9] [RL10]
  wire stopCond  = sclD & scl & ~sdaD & sda;     // [RL14]

  // ---------------------------------------------------------------------
  // protocol state machine
  // ---------------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_AACK = 3'h2;
  localparam [2:0] S_WR   = 3'h3;
  localparam [2:0] S_WACK = 3'h4;
  localparam [2:0] S_RD   = 3'h5;
  localparam [2:0] S_RACK = 3'h6;

  reg [2:0] state;
  reg [3:0] bitCnt;
  reg [7:0] shiftReg;
  reg       isWrite;
  reg       haveReg;
  reg [7:0] regPtr;
  reg [2:0] faultHeld;

  // read mux; out-of-range pointer reads all ones
  reg [7:0] rdByte;
  always @*
  begin
    rdByte = `UNMAPPED_DATA;                     // [RL16]
    if (regPtr == `REG_STATUS)
      rdByte = {statusIn[7:3], faultHeld};
    else if (regPtr < `REG_COUNT)
      rdByte = regRdData[(regPtr - 8'h01) * 8 +: 8];
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state     <= S_IDLE;
      bitCnt    <= 4'h0;
      shiftReg  <= 8'h00;
      isWrite   <= 1'b0;
      haveReg   <= 1'b0;
      regPtr    <= 8'h00;
      sdaOut    <= 1'b0;
      sdaOe     <= 1'b0;
      wrStrobe  <= 1'b0;
      wrAddr    <= 8'h00;
      wrData    <= 8'h00;
      faultRead <= 1'b0;
    end
    else
    begin
      wrStrobe  <= 1'b0;
      faultRead <= 1'b0;
      sdaOut    <= 1'b0;
      if (startCond)
      begin
        state   <= S_ADDR;                       // [RL9]
        bitCnt  <= 4'h0;
        haveReg <= 1'b0;
        sdaOe   <= 1'b0;
      end
      else if (stopCond)
      begin
        state <= S_IDLE;                         // [RL14] [RL15]
        sdaOe <= 1'b0;
      end
      else
      begin
        case (state)
          S_IDLE:
            sdaOe <= 1'b0;
          S_ADDR, S_WR:
          begin
            if (sclRise)
            begin
              shiftReg <= {shiftReg[6:0], sda};  // [RL12]
              bitCnt   <= bitCnt + 4'h1;
            end
            else if (sclFall && bitCnt == 4'h8)
            begin
              bitCnt <= 4'h0;
              if (state == S_ADDR)
              begin
                if (shiftReg[7:1] == `SLAVE_ADDR)  // [RL8]
                begin
                  isWrite <= shiftReg[0];          // [RL13]
                  sdaOe   <= 1'b1;                 // [RL11]
                  state   <= S_AACK;
                end
                else
                  state <= S_IDLE;
              end
              else
              begin
                if (!haveReg)
                begin
                  regPtr  <= shiftReg;             // [RL19]
                  haveReg <= 1'b1;
                end
                else
                begin
                  wrStrobe <= 1'b1;
                  wrAddr   <= regPtr;
                  wrData   <= shiftReg;
                  regPtr   <= regPtr + 8'h01;
                end
                sdaOe <= 1'b1;                     // [RL12]
                state <= S_WACK;
              end
            end
          end
          S_AACK, S_WACK:
          begin
            // ack held through the whole ninth high phase
            if (sclFall)
            begin
              if (state == S_AACK && !isWrite)
              begin
                sdaOe    <= ~rdByte[7];
                shiftReg <= {rdByte[6:0], 1'b1};
                bitCnt   <= 4'h1;
                if (regPtr == `REG_STATUS)
                  faultRead <= 1'b1;               // [RL17]
                state <= S_RD;
              end
              else
              begin
                sdaOe <= 1'b0;
                state <= S_WR;
              end
            end
          end
          S_RD:
          begin
            if (sclFall)
            begin
              if (bitCnt == 4'h8)
              begin
                sdaOe <= 1'b0;                     // release for master ack
                state <= S_RACK;
              end
              else
              begin
                sdaOe    <= ~shiftReg[7];
                shiftReg <= {shiftReg[6:0], 1'b1};
                bitCnt   <= bitCnt + 4'h1;
              end
            end
          end
          S_RACK:
          begin
            if (sclRise)
            begin
              if (sda)
                state <= S_IDLE;                   // master nack ends read
              else
                regPtr <= regPtr + 8'h01;
            end
            else if (sclFall)
            begin
              sdaOe    <= ~rdByte[7];
              shiftReg <= {rdByte[6:0], 1'b1};
              bitCnt   <= 4'h1;
              if (regPtr == `REG_STATUS)
                faultRead <= 1'b1;
              state <= S_RD;
            end
          end
          default:
            state <= S_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------
  // fault field: first fault wins, clears on read once gone
  // ---------------------------------------------------------------------
  // a fault present in the read cycle blocks the clear; the held code is kept
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      faultHeld <= 3'h0;
    else if (faultHeld == 3'h0)
      faultHeld <= faultCode;                      // [RL17]
    else if (faultRead && faultCode == 3'h0)
      faultHeld <= 3'h0;                           // [RL17]
  end

  // ---------------------------------------------------------------------
  // status and interrupt pins
  // ---------------------------------------------------------------------
  wire anyEvent = |eventIn;                        // [RL4]
  wire pulseOn;
  event_pulse_timer #(
    .PULSE_CYCLES (`PULSE_CYCLES)
  ) u_pulse (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .trigger (anyEvent),
    .pulseOn (pulseOn)
  );

  // pulse not gated by enable; steady low only when enabled
  wire pullLow = pulseOn | (charging & statEnable); // [RL1] [RL5] [RL3]
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      statOut <= 1'b0;
      statOe  <= 1'b0;
      intOut  <= 1'b0;
      intOe   <= 1'b0;
    end
    else
    begin
      statOut <= 1'b0;
      statOe  <= pullLow;                          // [RL2]
      intOut  <= 1'b0;
      intOe   <= pullLow;                          // [RL6]
    end
  end
  // rates are not distinguished: 400 kHz clock is far below sampling
  // [RL7]
endmodule // charger_host_interface

// >>> logic/event_pulse_timer.v
`timescale 1ns/1ps
module event_pulse_timer
#(
  parameter PULSE_CYCLES = 12800
)
(
  input  wire sys_clk,    // system clock
  input  wire rstn,       // async reset, active low
  input  wire trigger,    // one-cycle event
  output reg  pulseOn     // high while pulse runs
);
  reg [13:0] count;
  // terminal count cut to the counter width on purpose
  localparam [31:0] LAST_FULL = PULSE_CYCLES - 1;
  localparam [13:0] LAST      = LAST_FULL[13:0];

  // ---------------------------------------------------------------------
  // pulse counter
  // ---------------------------------------------------------------------
  // restart on new event so the host always sees a full pulse
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count   <= 14'h0000;
      pulseOn <= 1'b0;
    end
    else if (trigger)
    begin
      count   <= 14'h0000;          // [RL18]
      pulseOn <= 1'b1;
    end
    else if (pulseOn)
    begin
      if (count == LAST)
        pulseOn <= 1'b0;            // [RL3]
      count <= count + 14'h0001;
    end
  end
endmodule // event_pulse_timer

// >>> sim/bus_host.sv
`timescale 1ns/1ps
// ---
// bus master
// ---
module bus_host
#(
  parameter int Q = 30 // quarter bit in clocks
)
(
  input  wire logic sys_clk, // clock
  input  wire logic sdaOe,   // slave pulls low
  output logic      sclIn,   // bus clock
  output wire logic sdaIn    // data level
);
  logic sdaRel;
  // pull-up wins whenever nobody pulls low
  assign sdaIn = sdaRel & ~sdaOe;
  // bus idles high
  initial
  begin
    sclIn = 1'b1;
    sdaRel = 1'b1;
  end
  // one quarter bit at the given levels
  task automatic ph(input logic c, input logic d);
    sclIn = c;
    sdaRel = d;
    repeat (Q) @(negedge sys_clk);
  endtask
  // data falls with clock high
  task automatic bStart();
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
  endtask
  // data rises with clock high, also after aborts
  task automatic bStop();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  // data set while clock low, sampled mid high
  task automatic bt(input logic b, output logic s);
    ph(1'b0, b);
    ph(1'b1, b);
    s = sdaIn;
    ph(1'b1, b);
    ph(1'b0, b);
  endtask
  // msb first, then acknowledge from the receiver
  task automatic xfer(input logic [7:0] d, input logic ak,
                      output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      bt(d[i], r[i]);
    bt(ak, a);
  endtask
endmodule // bus_host

// >>> sim/charger_host_interface_properties.sv
`timescale 1ns/1ps
`include "charger_host_defs.vh"
// ---
// pin checker
// ---
module charger_host_checker
(
  input wire logic       sys_clk,    // clock
  input wire logic       rstn,       // reset
  input wire logic       sclIn,      // bus clock
  input wire logic       sdaOe,      // data pull
  input wire logic       charging,   // charging
  input wire logic       statEnable, // gate bit
  input wire logic [7:0] eventIn,    // events
  input wire logic       statOut,    // stat value
  input wire logic       statOe,     // stat pull
  input wire logic       intOut,     // int value
  input wire logic       intOe,      // int pull
  input wire logic       wrStrobe,   // write
  input wire logic       faultRead   // fault read
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  int   cnt;
  logic sawHold;
  wire  hold = charging && statEnable;
  // length of the current low phase; an event restarts it
  always @(posedge sys_clk or negedge rstn)
    if (!rstn)
      cnt <= 0;
    else if (!statOe || (|eventIn))
      cnt <= 0;
    else
      cnt <= cnt + 1;
  // a steady charging hold makes pulse length meaningless
  always @(posedge sys_clk or negedge rstn)
    if (!rstn)
      sawHold <= 1'b0;
    else
      sawHold <= statOe && (sawHold || hold);
  property p_mirror; intOe == statOe && intOut == statOut; endproperty
  a_mirror: assert property (p_mirror)
    else $error("int pin differs");
  property p_hold; hold && $past(hold, 3) |-> statOe; endproperty
  a_hold: assert property (p_hold)
    else $error("no steady low");
  property p_event; (|eventIn) |-> ##[1:4] statOe; endproperty
  a_event: assert property (p_event)
    else $error("event gave no pulse");
  property p_pulseMax; !sawHold |-> cnt <= `PULSE_CYCLES + 4; endproperty
  a_pulseMax: assert property (p_pulseMax)
    else $error("pulse too long");
  property p_pulseMin;
    $fell(statOe) && !$past(sawHold) |-> $past(cnt) >= `PULSE_CYCLES - 3;
  endproperty
  a_pulseMin: assert property (p_pulseMin)
    else $error("pulse too short");
  property p_sdaStable; sdaOe != $past(sdaOe) |-> !sclIn; endproperty
  a_sdaStable: assert property (p_sdaStable)
    else $error("data moved with clock high");
  property p_write; wrStrobe |-> !sclIn ##1 !wrStrobe; endproperty
  a_write: assert property (p_write)
    else $error("bad write strobe");
  property p_faultRead; faultRead |=> !faultRead; endproperty
  a_faultRead: assert property (p_faultRead)
    else $error("long fault read");
endmodule // charger_host_checker
bind charger_host_interface charger_host_checker i_charger_host_checker (
  .sys_clk, .rstn, .sclIn, .sdaOe, .charging, .statEnable, .eventIn,
  .statOut, .statOe, .intOut, .intOe, .wrStrobe, .faultRead);

// >>> sim/charger_host_interface_tb.sv
`timescale 1ns/1ps
`include "charger_host_defs.vh"
// ---
// scenarios
// ---
module charger_host_interface_tb;
  logic        sys_clk, rstn, charging, statEnable, a;
  logic [7:0]  eventIn, statusIn, r;
  logic [2:0]  faultCode;
  logic [55:0] regRdData;
  wire         sclIn, sdaIn, sdaOut, sdaOe, statOut, statOe;
  wire         intOut, intOe, wrStrobe, faultRead;
  wire  [7:0]  wrAddr, wrData;
  int          err_count, n_checks, cyc, frCnt;
  logic [15:0] wrLog [$];
  charger_host_interface i_charger_host_interface (.sys_clk, .rstn,
    .sclIn, .sdaIn, .sdaOut, .sdaOe, .charging, .statEnable, .eventIn,
    .faultCode, .statusIn, .regRdData, .statOut, .statOe, .intOut,
    .intOe, .wrStrobe, .wrAddr, .wrData, .faultRead);
  bus_host i_bus_host (.sys_clk, .sdaOe, .sclIn, .sdaIn);
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // log writes and fault reads; cut a hang short
  always @(posedge sys_clk)
  begin
    cyc++;
    if (wrStrobe === 1'b1)
      wrLog.push_back({wrAddr, wrData});
    if (faultRead === 1'b1)
      frCnt++;
    if (cyc == 100000)
    begin
      err_count++;
      test_done();
    end
  end
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // steady indication only with the gate bit set
  task automatic t_pins();
    chk({statOe, intOe, sdaOe}, 3'h0);
    chk({sdaOut, statOut, intOut}, 3'h0);
    charging = 1'b1;
    statEnable = 1'b1;
    w(5);
    chk({statOe, intOe}, 2'h3);
    statEnable = 1'b0;
    w(5);
    chk(statOe, 1'b0);
    charging = 1'b0;
    statEnable = 1'b1;
    w(5);
    chk(statOe, 1'b0);
  endtask
  // each event restarts the pulse before the old one could end
  task automatic t_events();
    charging = 1'b1;
    statEnable = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      eventIn = 8'h01 << i;
      w(1);
      eventIn = 8'h00;
      w(6300);
      chk({statOe, intOe}, 2'h3);
      if (i < 7)
        w(299);
    end
    w(`PULSE_CYCLES - 6310);
    chk(statOe, 1'b1);
    w(20);
    chk({statOe, intOe}, 2'h0);
    charging = 1'b0;
  endtask
  // pointer then two data bytes, direction one writes
  task automatic t_write();
    logic [7:0] wb [3] = '{8'h03, 8'hA5, 8'h5A};
    i_bus_host.bStart();
    i_bus_host.xfer({`SLAVE_ADDR, 1'b1}, 1'b1, r, a);
    chk(a, 1'b0);
    foreach (wb[i])
    begin
      i_bus_host.xfer(wb[i], 1'b1, r, a);
      chk(a, 1'b0);
    end
    i_bus_host.bStop();
    chk(wrLog.size(), 16'h2);
    chk(wrLog[0], 16'h03A5);
    chk(wrLog[1], 16'h045A);
  endtask
  // neighbouring address: no acknowledge, no write
  task automatic t_wrong();
    i_bus_host.bStart();
    i_bus_host.xfer({7'h6A, 1'b1}, 1'b1, r, a);
    chk(a, 1'b1);
    i_bus_host.xfer(8'h01, 1'b1, r, a);
    i_bus_host.xfer(8'h77, 1'b1, r, a);
    i_bus_host.bStop();
    chk(wrLog.size(), 16'h2);
    // cut a data byte short; the stop must leave no write behind
    i_bus_host.bStart();
    i_bus_host.xfer({`SLAVE_ADDR, 1'b1}, 1'b1, r, a);
    i_bus_host.xfer(8'h02, 1'b1, r, a);
    for (int i = 0; i < 3; i++)
      i_bus_host.bt(1'b0, a);
    i_bus_host.bStop();
    chk(wrLog.size(), 16'h2);
  endtask
  // set pointer, then read two bytes, ack then nack
  task automatic t_read(input logic [7:0] ptr, input logic [15:0] exp);
    i_bus_host.bStart();
    i_bus_host.xfer({`SLAVE_ADDR, 1'b1}, 1'b1, r, a);
    i_bus_host.xfer(ptr, 1'b1, r, a);
    i_bus_host.bStop();
    i_bus_host.bStart();
    i_bus_host.xfer({`SLAVE_ADDR, 1'b0}, 1'b1, r, a);
    chk(a, 1'b0);
    i_bus_host.xfer(8'hFF, 1'b0, r, a);
    chk(r, exp[15:8]);
    i_bus_host.xfer(8'hFF, 1'b1, r, a);
    chk(r, exp[7:0]);
    i_bus_host.bStop();
  endtask
  // first fault kept, cleared by a read once gone
  task automatic t_fault();
    faultCode = 3'h3;
    w(4);
    faultCode = 3'h5;
    w(4);
    faultCode = 3'h0;
    t_read(8'h00, 16'hAB11);
    chk(frCnt, 16'h1);
    t_read(8'h00, 16'hA811);
  endtask
  initial
  begin
    rstn = 1'b0;
    charging = 1'b0;
    statEnable = 1'b0;
    eventIn = 8'h00;
    faultCode = 3'h0;
    statusIn = 8'hA8;
    regRdData = 56'h00665544332211;
    w(16);
    rstn = 1'b1;
    w(4);
    t_pins();
    t_events();
    t_write();
    t_wrong();
    t_fault();
    t_read(8'h06, 16'h66FF);
    test_done();
  end
endmodule // charger_host_interface_tb
